// ### inc/lcm_pkg.sv
// Constants and types shared by the legacy compatibility gating block
package lcm_pkg;
   // Address map
   localparam int IO_PORT_SPAN = 64;            // Locations reachable by port-I/O opcodes
   localparam logic [15:0] IO_DS_BASE = 16'h0020;  // Data-space image of port-I/O slot 0
   localparam logic [15:0] EXT_LO = 16'h0060;   // Extended window first address
   localparam logic [15:0] EXT_HI = 16'h00ff;   // Extended window last address
   localparam logic [15:0] RAM_BASE_NORM = 16'h0100; // RAM start, native mode
   localparam logic [15:0] RAM_BASE_LEG = 16'h0060;  // RAM start, legacy mode
   localparam logic [5:0] LEGACY_VEC_NUM = 6'h18;    // Vectors kept in legacy mode
   // Reset-source flag positions
   localparam int RF_EXT = 0;                   // External reset flag
   localparam int RF_POR = 1;                   // Power-on reset flag
   localparam int RF_NUM = 5;                   // Flags in the native register
   localparam logic [4:0] RF_LEGACY_MASK = 5'h03;    // Flags kept in legacy mode
   localparam logic [4:0] RF_RST = 5'h00;       // Flags after reset
   // Reset values and timing
   localparam logic [7:0] OSC_CAL_RST = 8'h80;  // Oscillator trim after reset
   localparam logic [2:0] WDT_TO_RST = 3'h0;    // Watchdog time-out after reset
   localparam logic [3:0] BAUD_HI_ZERO = 4'h0;  // Upper divisor bits in legacy mode
   localparam int WDT_WIN_NS = 16;              // Change-enable window length
   localparam int CLK_NS = 4;                   // Core clock period
   localparam int WDT_WIN_CYC = WDT_WIN_NS / CLK_NS; // Window in cycles, rounds down
   localparam logic [1:0] RX_DEPTH_NORM = 2'h2; // Unread characters held, native
   localparam logic [1:0] RX_DEPTH_LEG = 2'h1;  // Unread characters held, legacy
   localparam logic [1:0] SENSE_LEVEL = 2'h0;   // Low-level interrupt sense code
   // Watchdog change-enable window states
   typedef enum logic [1:0] {
      WDT_IDLE = 2'b01,
      WDT_OPEN = 2'b10
   } lcm_wdt_state_t;
endpackage

// ### inc/lcm_dec_if.sv
// Signals between the gating top and its address and vector decoder
`timescale 1ns/1ps
interface lcm_dec_if;
   logic compat;          // Legacy mode, static after reset
   logic ds_valid;        // Data-space access this cycle
   logic [15:0] ds_addr;  // Data-space address
   logic io_instr;        // Port-I/O opcode access this cycle
   logic [5:0] io_addr;   // Port-I/O address
   logic [5:0] irq_num;   // Interrupt being vectored
   logic io_sel;          // Hit on a low I/O register
   logic ext_sel;         // Hit on an extended-window register
   logic ram_sel;         // Hit on internal RAM
   logic [15:0] reg_idx;  // Data-space address of the hit
   logic vec_valid;       // Vector exists in current table
   logic [6:0] vec_addr;  // Vector word address
   modport ctl (output compat, ds_valid, ds_addr, io_instr, io_addr, irq_num,
      input io_sel, ext_sel, ram_sel, reg_idx, vec_valid, vec_addr);
   modport dec (input compat, ds_valid, ds_addr, io_instr, io_addr, irq_num,
      output io_sel, ext_sel, ram_sel, reg_idx, vec_valid, vec_addr);
endinterface

// ### logic/lcm_decode.sv
// Address map and vector table decoder for native and legacy modes
`timescale 1ns/1ps
module lcm_decode (
   input wire logic i_core_clk,
   input wire logic i_rst,
   lcm_dec_if.dec bus
);
   logic [15:0] io_ds_addr;  // Port-I/O address moved into data space
   logic [15:0] eff_addr;    // Address actually decoded
   logic any_req;            // Some access this cycle
   logic hit_low;            // Inside the 64 low I/O slots
   logic hit_ext;            // Inside the extended window
   logic [15:0] ram_base;    // Start of RAM for this mode
   logic hit_ram;            // RAM hit
   logic vec_ok;             // Vector kept in this mode
   localparam logic [15:0] IO_DS_BASE_W = lcm_pkg::IO_DS_BASE; // Local copy for the sum

   // Port-I/O opcodes only ever reach the 64 low slots
   assign io_ds_addr = IO_DS_BASE_W + {10'h000, bus.io_addr};
   assign eff_addr = bus.io_instr ? io_ds_addr : bus.ds_addr;
   assign any_req = bus.io_instr | bus.ds_valid;
   // Low slots decode identically in both modes
   assign hit_low = any_req && eff_addr >= lcm_pkg::IO_DS_BASE && eff_addr < lcm_pkg::EXT_LO;
   // Extended window: load/store only, and gone in legacy mode
   assign hit_ext = bus.ds_valid && !bus.io_instr && !bus.compat
      && eff_addr >= lcm_pkg::EXT_LO && eff_addr <= lcm_pkg::EXT_HI;
   // Legacy mode moves RAM down over the window
   assign ram_base = bus.compat ? lcm_pkg::RAM_BASE_LEG : lcm_pkg::RAM_BASE_NORM;
   assign hit_ram = bus.ds_valid && !bus.io_instr && eff_addr >= ram_base;
   // Extended vectors vanish in legacy mode
   assign vec_ok = !bus.compat || bus.irq_num < lcm_pkg::LEGACY_VEC_NUM;

   // Registered decode results
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         bus.io_sel <= 1'b0;
         bus.ext_sel <= 1'b0;
         bus.ram_sel <= 1'b0;
         bus.reg_idx <= 16'h0000;
         bus.vec_valid <= 1'b0;
         bus.vec_addr <= 7'h00;
      end else begin
         bus.io_sel <= hit_low;
         bus.ext_sel <= hit_ext;
         bus.ram_sel <= hit_ram;
         bus.reg_idx <= eff_addr;
         bus.vec_valid <= vec_ok;
         bus.vec_addr <= {bus.irq_num, 1'b0};
      end
   end

   // Port-I/O opcode never lands in the window or RAM
   property p_io_low_only;
      @(posedge i_core_clk) disable iff (i_rst)
      bus.io_instr |=> !bus.ext_sel && !bus.ram_sel && bus.io_sel;
   endproperty
   a_io_low_only: assert property (p_io_low_only)
      else $error("port-I/O access left the low I/O space");

   // Legacy mode window address goes to RAM
   property p_leg_window_ram;
      @(posedge i_core_clk) disable iff (i_rst)
      (bus.compat && bus.ds_valid && !bus.io_instr && bus.ds_addr == 16'h0060)
      |=> bus.ram_sel && !bus.ext_sel;
   endproperty
   a_leg_window_ram: assert property (p_leg_window_ram)
      else $error("legacy window address not mapped to RAM");

   // Legacy mode drops high vectors
   property p_leg_vec;
      @(posedge i_core_clk) disable iff (i_rst)
      (bus.compat && bus.irq_num >= 6'h18) |=> !bus.vec_valid;
   endproperty
   a_leg_vec: assert property (p_leg_vec)
      else $error("extended vector present in legacy mode");
endmodule

// ### logic/lcm_gate.sv
// Legacy compatibility mode gating of address map, peripherals and pins
//
// Overview of operation
// - Port-I/O opcodes reach only 64 locations.
// - Legacy I/O registers keep their addresses.
// - Extended window 0x60-0xFF, load/store only.
// - Legacy mode: window off, RAM relocated.
// - Legacy mode drops extended interrupt vectors.
// - One serial port, async, low divisor bits.
// - One 16-bit timer, two compare registers.
// - Two-wire interface unavailable in legacy mode.
// - Port C output only in legacy mode.
// - Port G alternate functions only.
// - Port F digital input only.
// - Boot-loader self-programming disabled.
// - Oscillator trim writes ignored.
// - Bus keeps all address pins, single wait-state.
// - Only external and power-on reset flags.
// - Watchdog time-out change needs no sequence.
// - External interrupts 3..0 level only.
// - No receive FIFO, earlier overrun.
// - Port C keeps driving during reset.
// - Strobe pins forced 1,1,0 during reset.
`timescale 1ns/1ps
module lcm_gate #(
   parameter int BAUD_W = 12,   // Full baud divisor width
   parameter int INT_NUM = 4    // External interrupts forced to level sense
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_legacy_compat_fuse,      // Fuse level, outside clock domain
   input wire logic i_ds_valid,
   input wire logic [15:0] i_ds_addr,
   input wire logic i_io_instr,
   input wire logic [5:0] i_io_addr,
   input wire logic [5:0] i_irq_num,
   input wire logic [BAUD_W-1:0] i_baud_div,
   input wire logic i_usart_sync_req,
   input wire logic [7:0] i_portc_dir,
   input wire logic [7:0] i_portf_dir,
   input wire logic i_osc_cal_wr,
   input wire logic [7:0] i_osc_cal_data,
   input wire logic [2:0] i_xmem_release,
   input wire logic i_xmem_sector_ws,
   input wire logic [4:0] i_rst_src,            // Reset-source events, one per flag
   input wire logic i_rst_flag_clr,             // Software clear of the flags
   input wire logic i_wdt_chg_en,               // Timed sequence opening write
   input wire logic i_wdt_to_wr,
   input wire logic [2:0] i_wdt_to_data,
   input wire logic [2*INT_NUM-1:0] i_int_sense,
   input wire logic i_rx_char_done,
   input wire logic i_rx_read,
   output logic o_compat,
   output logic o_io_sel,
   output logic o_ext_sel,
   output logic o_ram_sel,
   output logic [15:0] o_reg_idx,
   output logic o_vec_valid,
   output logic [6:0] o_vec_addr,
   output logic o_usart1_en,
   output logic o_usart_sync_en,
   output logic [BAUD_W-1:0] o_baud_div,
   output logic o_timer3_en,
   output logic o_cmp_c_en,
   output logic o_twi_en,
   output logic [7:0] o_portc_oe_n,
   output logic o_portc_in_en,
   output logic o_portg_gpio_en,
   output logic [7:0] o_portf_oe_n,
   output logic o_boot_selfprog_en,
   output logic [7:0] o_osc_cal,
   output logic [2:0] o_xmem_release,
   output logic o_xmem_sector_ws,
   output logic [4:0] o_cpu_control_status_reg,
   output logic [2:0] o_wdt_timeout,
   output logic [2*INT_NUM-1:0] o_int_sense,
   output logic o_rx_overrun,
   output logic o_strobe_pin_zero,
   output logic o_strobe_pin_one,
   output logic o_strobe_pin_two,
   output logic o_strobe_oe_n
);
   logic fuse_s1_q;             // Synchroniser stage one
   logic fuse_s2_q;             // Synchroniser stage two
   logic compat_q;              // Latched mode
   logic [7:0] osc_cal_q;
   logic [4:0] rf_q;
   logic [4:0] rf_d;
   lcm_pkg::lcm_wdt_state_t wdt_st_q;
   lcm_pkg::lcm_wdt_state_t wdt_st_d;
   logic [2:0] wdt_cnt_q;       // Cycles left in the open window
   logic [2:0] wdt_to_q;
   logic wdt_accept;            // Time-out write takes effect
   logic [1:0] rx_cnt_q;        // Unread characters held
   logic [1:0] rx_depth;
   logic rx_full;
   logic [1:0] rx_cnt_d;
   logic rx_ovr_q;
   logic [2*INT_NUM-1:0] sense_q;
   logic [BAUD_W-1:0] baud_eff;

   lcm_dec_if dec_if ();

   // Fuse level crosses into the clock domain
   always_ff @(posedge i_core_clk) begin
      fuse_s1_q <= i_legacy_compat_fuse;
      fuse_s2_q <= fuse_s1_q;
   end

   // Mode follows the fuse only while reset is held, then freezes
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         compat_q <= fuse_s2_q;
      end
   end

   assign dec_if.compat = compat_q;
   assign dec_if.ds_valid = i_ds_valid;
   assign dec_if.ds_addr = i_ds_addr;
   assign dec_if.io_instr = i_io_instr;
   assign dec_if.io_addr = i_io_addr;
   assign dec_if.irq_num = i_irq_num;

   // Address map and vector table
   lcm_decode u_decode (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .bus(dec_if.dec)
   );

   assign o_io_sel = dec_if.io_sel;
   assign o_ext_sel = dec_if.ext_sel;
   assign o_ram_sel = dec_if.ram_sel;
   assign o_reg_idx = dec_if.reg_idx;
   assign o_vec_valid = dec_if.vec_valid;
   assign o_vec_addr = dec_if.vec_addr;

   // Legacy divisor keeps only its low byte
   localparam logic [BAUD_W-9:0] BAUD_HI_ZERO_W = '0;
   assign baud_eff = compat_q ? {BAUD_HI_ZERO_W, i_baud_div[7:0]} : i_baud_div;

   // Static peripheral enables; outputs kept registered for clean fan-out
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_compat <= 1'b0;
         o_usart1_en <= 1'b0;
         o_usart_sync_en <= 1'b0;
         o_baud_div <= '0;
         o_timer3_en <= 1'b0;
         o_cmp_c_en <= 1'b0;
         o_twi_en <= 1'b0;
         o_portc_in_en <= 1'b0;
         o_portg_gpio_en <= 1'b0;
         o_boot_selfprog_en <= 1'b0;
         o_xmem_release <= 3'h0;
         o_xmem_sector_ws <= 1'b0;
      end else begin
         o_compat <= compat_q;
         o_usart1_en <= !compat_q;
         o_usart_sync_en <= !compat_q && i_usart_sync_req;
         o_baud_div <= baud_eff;
         o_timer3_en <= !compat_q;
         o_cmp_c_en <= !compat_q;
         o_twi_en <= !compat_q;
         o_portc_in_en <= !compat_q;
         o_portg_gpio_en <= !compat_q;
         o_boot_selfprog_en <= !compat_q;
         o_xmem_release <= compat_q ? 3'h0 : i_xmem_release;
         o_xmem_sector_ws <= !compat_q && i_xmem_sector_ws;
      end
   end

   // Port C drives in legacy mode even through reset
   always_ff @(posedge i_core_clk) begin
      if (compat_q) begin
         o_portc_oe_n <= 8'h00;
      end else if (i_rst) begin
         o_portc_oe_n <= 8'hff;
      end else begin
         o_portc_oe_n <= ~i_portc_dir;
      end
   end

   // Port F never drives in legacy mode
   always_ff @(posedge i_core_clk) begin
      if (i_rst || compat_q) begin
         o_portf_oe_n <= 8'hff;
      end else begin
         o_portf_oe_n <= ~i_portf_dir;
      end
   end

   // Oscillator trim; legacy mode ignores writes
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         osc_cal_q <= lcm_pkg::OSC_CAL_RST;
      end else if (i_osc_cal_wr && !compat_q) begin
         osc_cal_q <= i_osc_cal_data;
      end
   end
   assign o_osc_cal = osc_cal_q;

   // Sticky reset flags: a new event beats a clear in the same cycle
   assign rf_d = (i_rst_flag_clr ? 5'h00 : rf_q) | i_rst_src;

   // Flags outlive the core reset so software can read the cause
   always_ff @(posedge i_core_clk) begin
      rf_q <= rf_d;
   end

   // Legacy view keeps external and power-on flags only
   always_ff @(posedge i_core_clk) begin
      o_cpu_control_status_reg <= compat_q ? (rf_d & lcm_pkg::RF_LEGACY_MASK) : rf_d;
   end

   // Change-enable window for the watchdog time-out
   always_comb begin
      wdt_st_d = wdt_st_q;
      case (wdt_st_q)
         lcm_pkg::WDT_IDLE: begin
            if (i_wdt_chg_en) begin
               wdt_st_d = lcm_pkg::WDT_OPEN;
            end
         end
         lcm_pkg::WDT_OPEN: begin
            if (wdt_cnt_q == 3'h1 || i_wdt_to_wr) begin
               wdt_st_d = lcm_pkg::WDT_IDLE;
            end
         end
         default: begin
            wdt_st_d = lcm_pkg::WDT_IDLE;
         end
      endcase
   end

   // Legacy mode takes a time-out write with no opening write
   assign wdt_accept = i_wdt_to_wr && (compat_q || wdt_st_q == lcm_pkg::WDT_OPEN);

   // Window state, countdown and time-out value
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wdt_st_q <= lcm_pkg::WDT_IDLE;
         wdt_cnt_q <= 3'h0;
         wdt_to_q <= lcm_pkg::WDT_TO_RST;
      end else begin
         wdt_st_q <= wdt_st_d;
         if (i_wdt_chg_en && wdt_st_q == lcm_pkg::WDT_IDLE) begin
            wdt_cnt_q <= 3'(lcm_pkg::WDT_WIN_CYC);
         end else if (wdt_cnt_q != 3'h0) begin
            wdt_cnt_q <= wdt_cnt_q - 3'h1;
         end
         if (wdt_accept) begin
            wdt_to_q <= i_wdt_to_data;
         end
      end
   end
   assign o_wdt_timeout = wdt_to_q;

   // Each interrupt's sense pair is forced to level in legacy mode
   genvar gi;
   generate
      for (gi = 0; gi < INT_NUM; gi++) begin : g_sense
         always_ff @(posedge i_core_clk) begin
            if (i_rst || compat_q) begin
               sense_q[2*gi+1:2*gi] <= lcm_pkg::SENSE_LEVEL;
            end else begin
               sense_q[2*gi+1:2*gi] <= i_int_sense[2*gi+1:2*gi];
            end
         end
      end
   endgenerate
   assign o_int_sense = sense_q;

   // Receive holding depth shrinks without the FIFO
   assign rx_depth = compat_q ? lcm_pkg::RX_DEPTH_LEG : lcm_pkg::RX_DEPTH_NORM;
   assign rx_full = rx_cnt_q >= rx_depth;
   always_comb begin
      rx_cnt_d = rx_cnt_q;
      if (i_rx_char_done && !rx_full && !i_rx_read) begin
         rx_cnt_d = rx_cnt_q + 2'h1;
      end else if (i_rx_read && !i_rx_char_done && rx_cnt_q != 2'h0) begin
         rx_cnt_d = rx_cnt_q - 2'h1;
      end
   end

   // Overrun is sticky; a read clears it, even when a new character arrives in the same cycle
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rx_cnt_q <= 2'h0;
         rx_ovr_q <= 1'b0;
      end else begin
         rx_cnt_q <= rx_cnt_d;
         if (i_rx_char_done && rx_full && !i_rx_read) begin
            rx_ovr_q <= 1'b1;
         end else if (i_rx_read) begin
            rx_ovr_q <= 1'b0;
         end
      end
   end
   assign o_rx_overrun = rx_ovr_q;

   // Strobe levels set with no clock; value flops only, enable is clocked
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_strobe_pin_zero <= 1'b1;
         o_strobe_pin_one <= 1'b1;
         o_strobe_pin_two <= 1'b0;
      end else begin
         o_strobe_pin_zero <= 1'b1;
         o_strobe_pin_one <= 1'b1;
         o_strobe_pin_two <= 1'b0;
      end
   end

   // Strobes drive in legacy mode, float in native mode during reset
   always_ff @(posedge i_core_clk) begin
      o_strobe_oe_n <= !compat_q;
   end

   // Mode holds after reset release
   property p_mode_static;
      @(posedge i_core_clk) disable iff (i_rst)
      $stable(compat_q);
   endproperty
   a_mode_static: assert property (p_mode_static)
      else $error("compatibility mode changed outside reset");

   property p_twi_off;
      @(posedge i_core_clk) disable iff (i_rst)
      compat_q |=> !o_twi_en && !o_timer3_en && !o_cmp_c_en && !o_usart1_en;
   endproperty
   a_twi_off: assert property (p_twi_off)
      else $error("native peripheral enabled in legacy mode");

   property p_baud_low;
      @(posedge i_core_clk) disable iff (i_rst)
      compat_q |=> o_baud_div[BAUD_W-1:8] == '0 && o_baud_div[7:0] == $past(i_baud_div[7:0]);
   endproperty
   a_baud_low: assert property (p_baud_low)
      else $error("legacy baud divisor not limited to low byte");

   property p_portc_drive;
      @(posedge i_core_clk) compat_q ##1 compat_q |-> o_portc_oe_n == 8'h00;
   endproperty
   a_portc_drive: assert property (p_portc_drive)
      else $error("port C released in legacy mode");

   property p_portf_in;
      @(posedge i_core_clk) disable iff (i_rst)
      compat_q |=> o_portf_oe_n == 8'hff;
   endproperty
   a_portf_in: assert property (p_portf_in)
      else $error("port F driving in legacy mode");

   property p_cal_hold;
      @(posedge i_core_clk) disable iff (i_rst)
      compat_q |=> $stable(o_osc_cal);
   endproperty
   a_cal_hold: assert property (p_cal_hold)
      else $error("oscillator trim changed in legacy mode");

   property p_flags_legacy;
      @(posedge i_core_clk) disable iff (i_rst)
      compat_q |=> o_cpu_control_status_reg[4:2] == 3'h0;
   endproperty
   a_flags_legacy: assert property (p_flags_legacy)
      else $error("extra reset flag visible in legacy mode");

   property p_wdt_direct;
      @(posedge i_core_clk) disable iff (i_rst)
      (compat_q && i_wdt_to_wr) |=> o_wdt_timeout == $past(i_wdt_to_data);
   endproperty
   a_wdt_direct: assert property (p_wdt_direct)
      else $error("legacy watchdog time-out write not taken");

   property p_sense_level;
      @(posedge i_core_clk) disable iff (i_rst)
      compat_q |=> o_int_sense == '0;
   endproperty
   a_sense_level: assert property (p_sense_level)
      else $error("edge sense selected in legacy mode");

   property p_rx_early;
      @(posedge i_core_clk) disable iff (i_rst)
      (compat_q && rx_cnt_q == 2'h1 && i_rx_char_done && !i_rx_read) |=> o_rx_overrun;
   endproperty
   a_rx_early: assert property (p_rx_early)
      else $error("legacy overrun not flagged on second unread character");
endmodule

// ### verification/lcm_core_model.sv
// Core and receiver stand-in driving the far side of the gating block
`timescale 1ns/1ps
module lcm_core_model (
   input wire logic i_compat,
   input wire logic i_send,
   input wire logic i_take,
   input wire logic [7:0] i_dir_req,
   output logic o_char_done,
   output logic o_read,
   output logic [7:0] o_portc_dir
);
   // Receiver hands over one character per send pulse
   assign o_char_done = i_send;
   // Reader consumes a character per take pulse
   assign o_read = i_take;
   // Legacy code leaves the unused direction bits at zero
   assign o_portc_dir = i_compat ? 8'h00 : i_dir_req;
endmodule

// ### verification/lcm_gate_tb_top.sv
// Self-checking bench for the legacy compatibility gating block
`timescale 1ns/1ps
module lcm_gate_tb_top;
   typedef struct {int s; logic [31:0] e;} lcm_note_t;
   logic i_core_clk = 1'b0, i_rst = 1'b1, i_legacy_compat_fuse = 1'b0, i_ds_valid = 1'b0;
   logic i_io_instr = 1'b0, i_usart_sync_req = 1'b0, i_osc_cal_wr = 1'b0, i_rst_flag_clr = 1'b0;
   logic i_xmem_sector_ws = 1'b0, i_wdt_chg_en = 1'b0, i_wdt_to_wr = 1'b0, send = 1'b0;
   logic take = 1'b0; // Reader pulse into the core model
   logic [15:0] i_ds_addr = 16'h0;
   logic [5:0] i_io_addr = 6'h0, i_irq_num = 6'h0;
   logic [11:0] i_baud_div = 12'h0;
   logic [7:0] i_portf_dir = 8'h0, i_osc_cal_data = 8'h0, i_int_sense = 8'h0, dir = 8'h0;
   logic [2:0] i_xmem_release = 3'h0, i_wdt_to_data = 3'h0;
   logic [4:0] i_rst_src = 5'h0;
   wire logic i_rx_char_done, i_rx_read;
   wire logic [7:0] i_portc_dir;
   logic o_compat, o_io_sel, o_ext_sel, o_ram_sel, o_vec_valid, o_usart1_en, o_usart_sync_en;
   logic o_timer3_en, o_cmp_c_en, o_twi_en, o_portc_in_en, o_portg_gpio_en, o_boot_selfprog_en;
   logic o_xmem_sector_ws, o_rx_overrun, o_strobe_pin_zero, o_strobe_pin_one, o_strobe_pin_two;
   logic o_strobe_oe_n;
   logic [15:0] o_reg_idx;
   logic [6:0] o_vec_addr;
   logic [11:0] o_baud_div;
   logic [7:0] o_portc_oe_n, o_portf_oe_n, o_osc_cal, o_int_sense;
   logic [2:0] o_xmem_release, o_wdt_timeout;
   logic [4:0] o_cpu_control_status_reg;
   lcm_note_t q[$]; // Expected results awaiting the monitor
   int n_mismatch = 0, n_checks = 0, cyc = 0, seed = 93480;
   lcm_gate DUT (.*);
   lcm_core_model core (.i_compat(o_compat), .i_send(send), .i_take(take), .i_dir_req(dir),
      .o_char_done(i_rx_char_done), .o_read(i_rx_read), .o_portc_dir(i_portc_dir));
   // 250 MHz core clock
   initial begin
      forever #2 i_core_clk = ~i_core_clk;
   end
   // Verdict and end of run, reached from the hang guard and the main sequence
   task automatic end_sim;
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Output group picked by selector
   function automatic logic [31:0] obs(int s);
      case (s)
         0: obs = {13'h0, o_io_sel, o_ext_sel, o_ram_sel, o_reg_idx};
         1: obs = {24'h0, o_vec_valid, o_vec_addr};
         2: obs = {20'h0, o_usart1_en, o_usart_sync_en, o_timer3_en, o_cmp_c_en, o_twi_en,
            o_portc_in_en, o_portg_gpio_en, o_boot_selfprog_en, o_xmem_sector_ws, o_xmem_release};
         3: obs = {20'h0, o_baud_div};
         4: obs = {16'h0, o_portc_oe_n, o_portf_oe_n};
         5: obs = {24'h0, o_osc_cal};
         6: obs = {29'h0, o_wdt_timeout};
         7: obs = {24'h0, o_int_sense};
         8: obs = {27'h0, o_cpu_control_status_reg};
         9: obs = {31'h0, o_rx_overrun};
         default: obs = {27'h0, o_compat, o_strobe_pin_zero, o_strobe_pin_one, o_strobe_pin_two,
            o_strobe_oe_n};
      endcase
   endfunction
   task automatic note(int s, logic [31:0] e);
      q.push_back('{s, e});
   endtask
   task automatic st;
      @(posedge i_core_clk);
   endtask
   // Single compare point for every noted result
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Monitor compares settled outputs with the oldest notes
   always @(negedge i_core_clk) begin
      while (q.size() > 0) begin
         lcm_note_t n;
         n = q.pop_front();
         chk(obs(n.s), n.e);
      end
   end
   // Hang guard, well above the two mode passes
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         end_sim;
      end
   end
   // One full pass in the mode given by the fuse level
   task automatic run(logic f);
      logic [11:0] b;
      b = 12'($random(seed));
      i_legacy_compat_fuse <= f;
      i_rst <= 1'b1;
      repeat (4) st;
      note(10, {27'h0, 1'b0, 3'b110, ~f});
      note(4, {16'h0, f ? 8'h00 : 8'hff, 8'hff});
      i_rst <= 1'b0;
      i_io_instr <= 1'b1;
      i_io_addr <= 6'h3f;
      i_irq_num <= 6'h18;
      i_baud_div <= b;
      {i_usart_sync_req, i_xmem_sector_ws, i_xmem_release} <= 5'h1f;
      {dir, i_portf_dir, i_int_sense} <= 24'hffffff;
      i_osc_cal_wr <= 1'b1;
      i_osc_cal_data <= 8'h5a;
      i_rst_src <= 5'h1f;
      i_wdt_to_wr <= 1'b1;
      i_wdt_to_data <= 3'h5;
      st;
      note(0, {13'h0, 3'b100, 16'h005f});
      note(1, {24'h0, ~f, 7'h30});
      note(2, f ? 32'h0 : 32'hfff);
      note(3, {20'h0, f ? {4'h0, b[7:0]} : b});
      note(4, {16'h0, 8'h00, f ? 8'hff : 8'h00});
      note(5, {24'h0, f ? 8'h80 : 8'h5a});
      note(6, {29'h0, f ? 3'h5 : 3'h0});
      note(7, {24'h0, f ? 8'h00 : 8'hff});
      note(8, {27'h0, f ? 5'h03 : 5'h1f});
      note(10, {27'h0, f, 3'b110, ~f});
      {i_io_instr, i_osc_cal_wr, i_wdt_to_wr, i_rst_src} <= 8'h0;
      i_ds_valid <= 1'b1;
      i_ds_addr <= 16'h0060;
      i_irq_num <= 6'h17;
      st;
      note(0, {13'h0, 1'b0, ~f, f, 16'h0060});
      note(1, {24'h0, 1'b1, 7'h2e});
      i_ds_addr <= 16'h0100;
      i_wdt_chg_en <= 1'b1;
      // Clear and a new power-on event together: the event must survive
      {i_rst_flag_clr, i_rst_src} <= 6'h22;
      st;
      note(0, {13'h0, 3'b001, 16'h0100});
      note(8, {27'h0, 5'h02});
      {i_rst_flag_clr, i_rst_src} <= 6'h00;
      i_wdt_chg_en <= 1'b0;
      i_wdt_to_wr <= 1'b1;
      i_wdt_to_data <= 3'h3;
      st;
      note(6, {29'h0, 3'h3});
      i_wdt_to_wr <= 1'b0;
      i_ds_valid <= 1'b0;
      // Unread characters pile up until the receiver overruns
      for (int k = 1; k <= 3; k++) begin
         send <= 1'b1;
         st;
         send <= 1'b0;
         st;
         note(9, {31'h0, k > (f ? 1 : 2)});
      end
      // A read frees a slot and clears the sticky overrun
      take <= 1'b1;
      st;
      take <= 1'b0;
      st;
      note(9, 32'h0);
      st;
   endtask
   // Native pass, then a mid-run reset into legacy mode
   initial begin
      run(1'b0);
      run(1'b1);
      end_sim;
   end
endmodule
